// [verilog/pwm_sweep_defines.svh]
// constants for the pwm sweep generator and its host end
// assumes: included by bare name after the package
`ifndef PWM_SWEEP_DEFINES_SVH
`define PWM_SWEEP_DEFINES_SVH

`define NUM_PORTS      4
`define SCAN_PORT_IDX  3
`define CMD_BITS       3'h7
`define OP_LEVEL_HI    4'h8
`define OP_LEVEL_LO    4'h7
`define OP_SLOPE       4'h9
`define OP_PROG_ON     4'hC
`define OP_TEST        4'hF
`define OP_FREQ        6'h14
`define OP_SELECT      6'h18
`define OP_MODE        6'h19
`define OP_RESET       8'hE2
`define TEST_NORMAL    4'h0
`define SLOPE_HALT     2'h0
`define SLOPE_UP       2'h1
`define SLOPE_DOWN     2'h2
`define SLOPE_IGNORE   2'h3
`define LEVEL_MIN      8'h00
`define GEN_FULL       8'h80
`define STEP_SHIFT_GEN 3'h2
`define STEP_SHIFT_LED 3'h3
`define PHASE_WRAP_128 8'h7F
`define PHASE_WRAP_256 8'hFF
`define LED_DUTY_TABLE '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0D, 8'h13, \
                         8'h1B, 8'h24, 8'h2E, 8'h3B, 8'h49, 8'h5A, 8'h6C, 8'h80}

`endif

// [verilog/pwm_sweep_pkg.sv]
// types shared by the device end and the host end
// assumes: compiled before every other file
`default_nettype none

package pwm_sweep_pkg;

    typedef logic [7:0] level_t;

    typedef enum logic [4:0]
    {
        H_IDLE = 5'b00001,
        H_LOW  = 5'b00010,
        H_HIGH = 5'b00100,
        H_HOLD = 5'b01000,
        H_OFF  = 5'b10000
    } host_state_t;

    typedef struct packed
    {
        level_t     data;
        level_t     count;
        level_t     level;
        logic       led;
        logic [1:0] slope;
        logic [1:0] step_t;
        logic       run;
        logic       load;
        level_t     steps;
        logic [5:0] fcnt;
    } port_state_t;

endpackage

`default_nettype wire

// [verilog/pwm_link_if.sv]
// serial instruction link between host and pwm sweep device
// assumes: testbench instantiates it and joins both ends
`timescale 1ns/1ps
`default_nettype none

interface pwm_link_if;
    logic ce;
    logic scl;
    logic ser_din;
    logic req_o;
    logic req_oe_n;
    logic serial_data_line;

    // open-drain request with pull-up
    assign serial_data_line = req_oe_n ? 1'b1 : req_o;

    modport device
    (
        input  ce,
        input  scl,
        input  ser_din,
        output req_o,
        output req_oe_n
    );

    modport host
    (
        output ce,
        output scl,
        output ser_din,
        input  serial_data_line
    );
endinterface

`default_nettype wire

// [verilog/pwm_sweep_device.sv]
// device end: four pwm ports with sweep program and request line
// assumes: link pins asynchronous to clk_sys, host drives them slowly
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sweep_defines.svh"

// Summary of operation
// - without sweep, new level applies next frame
// - host loads level and step, then program-on
// - upper nibble first; lower nibble commits level
// - 8-bit level shared, opcodes 1000 and 0111
// - general mode: level/128, msb gives full
// - led mode: low nibble through duty table
// - sweep wraps at extremes and keeps counting
// - stepping time code sets frames per step
// - slope 1001: halt, up, down, ignore
// - program-on 1100 starts sweep per bit
// - sweeps need enable; start bits self-clear
// - finish holds level, pulls data line low
// - request asserted as program's last frame ends
// - request held until next host write
// - disabling sweep aborts without any request
// - test opcode escaped by reset instruction or pin
// - port select routes level, mode, step writes
// - general has 128 steps, led 16 steps
// - frequency bit picks period 128 or 256
module pwm_sweep_device
    import pwm_sweep_pkg::*;
#(
    parameter int PORTS   = 4,
    parameter int SYS_DIV = 1
)
(
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    pwm_link_if.device            link,
    output logic [PORTS-1:0]      pwm_out_ports,
    output logic                  test_active
);

    localparam int DW = $clog2(SYS_DIV) + 1;
    localparam level_t LED_DUTY [16] = `LED_DUTY_TABLE;

    if (PORTS != `NUM_PORTS)
    begin : g_chk_ports
        $error("PORTS must be 4");
    end
    if (SYS_DIV < 1)
    begin : g_chk_div
        $error("SYS_DIV must be at least 1");
    end

    function automatic level_t duty_of(input level_t lvl, input logic led);
        level_t d;
        d = lvl[7] ? `GEN_FULL : {1'b0, lvl[6:0]};
        if (led)
        begin
            d = LED_DUTY[lvl[3:0]];
        end
        return d;
    endfunction

    function automatic logic [5:0] step_frames(input logic [1:0] st, input logic led);
        return ({4'h0, st} + 6'h01) << (led ? `STEP_SHIFT_LED : `STEP_SHIFT_GEN);
    endfunction

    function automatic level_t next_level(input level_t lvl, input logic [1:0] sl,
                                          input logic led);
        level_t g;
        level_t n;
        g = lvl[7] ? `GEN_FULL : lvl;
        n = lvl;
        if (sl == `SLOPE_UP)
        begin
            n = led ? {4'h0, lvl[3:0] + 4'h1}
                    : ((g == `GEN_FULL) ? `LEVEL_MIN : g + 8'h01);
        end
        else if (sl == `SLOPE_DOWN)
        begin
            n = led ? {4'h0, lvl[3:0] - 4'h1}
                    : ((g == `LEVEL_MIN) ? `GEN_FULL : g - 8'h01);
        end
        return n;
    endfunction

    // link synchronisers, bit 0 is read only by bit 1
    logic [2:0]        ce_s_q;
    logic [2:0]        scl_s_q;
    logic [1:0]        din_s_q;
    logic [2:0]        bit_q;
    logic [6:0]        shift_q;
    logic              cmd_stb_q;
    logic [7:0]        cmd_q;

    logic [1:0]        sel_q;
    logic              freq_q;
    logic              keyscan_q;
    logic              sweep_en_q;
    logic [3:0]        upper_q;
    logic              test_q;
    logic              req_q;
    logic [DW-1:0]     div_q;
    logic [7:0]        phase_q;
    port_state_t       st_q [PORTS];
    port_state_t       st_d [PORTS];
    logic [PORTS-1:0]  out_d;
    logic              done_any;
    logic              hit;
    logic [6:0]        cmp;

    wire scl_rise  = scl_s_q[1] & ~scl_s_q[2];
    wire byte_done = ce_s_q[1] & scl_rise & (bit_q == `CMD_BITS);
    wire sclr      = cmd_stb_q & (cmd_q == `OP_RESET);
    wire live      = cmd_stb_q & ~test_q & ~sclr;
    wire wr_hi     = live & (cmd_q[7:4] == `OP_LEVEL_HI);
    wire wr_lo     = live & (cmd_q[7:4] == `OP_LEVEL_LO);
    wire wr_slope  = live & (cmd_q[7:4] == `OP_SLOPE)
                   & (cmd_q[3:2] != `SLOPE_IGNORE);
    wire prog_on   = live & (cmd_q[7:4] == `OP_PROG_ON) & sweep_en_q;
    wire wr_test   = cmd_stb_q & (cmd_q[7:4] == `OP_TEST);
    wire wr_freq   = live & (cmd_q[7:2] == `OP_FREQ);
    wire wr_sel    = live & (cmd_q[7:2] == `OP_SELECT);
    wire wr_mode   = live & (cmd_q[7:2] == `OP_MODE);
    wire abort     = wr_mode & ~cmd_q[0];
    wire sys_en    = (div_q == DW'(SYS_DIV - 1));
    wire [7:0] wrap = freq_q ? `PHASE_WRAP_256 : `PHASE_WRAP_128;
    wire frame_end = sys_en & (phase_q >= wrap);

    assign link.req_o   = 1'b0;
    assign link.req_oe_n = ~req_q;
    assign test_active  = test_q;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ce_s_q    <= '0;
            scl_s_q   <= '0;
            din_s_q   <= '0;
            bit_q     <= '0;
            shift_q   <= '0;
            cmd_stb_q <= 1'b0;
            cmd_q     <= '0;
        end
        else
        begin
            ce_s_q    <= {ce_s_q[1:0], link.ce};
            scl_s_q   <= {scl_s_q[1:0], link.scl};
            din_s_q   <= {din_s_q[0], link.ser_din};
            bit_q     <= !ce_s_q[1] ? '0 : (scl_rise ? bit_q + 3'h1 : bit_q);
            shift_q   <= scl_rise ? {shift_q[5:0], din_s_q[1]} : shift_q;
            cmd_stb_q <= byte_done;
            cmd_q     <= byte_done ? {shift_q, din_s_q[1]} : cmd_q;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sel_q      <= '0;
            freq_q     <= 1'b0;
            keyscan_q  <= 1'b0;
            sweep_en_q <= 1'b0;
            upper_q    <= '0;
            test_q     <= 1'b0;
            req_q      <= 1'b0;
            div_q      <= '0;
            phase_q    <= '0;
        end
        else
        begin
            sel_q      <= sclr ? '0 : (wr_sel ? cmd_q[1:0] : sel_q);
            freq_q     <= sclr ? 1'b0 : (wr_freq ? cmd_q[0] : freq_q);
            keyscan_q  <= sclr ? 1'b0 : (wr_freq ? cmd_q[1] : keyscan_q);
            sweep_en_q <= sclr ? 1'b0 : (wr_mode ? cmd_q[0] : sweep_en_q);
            upper_q    <= sclr ? '0 : (wr_hi ? cmd_q[3:0] : upper_q);
            test_q     <= sclr ? 1'b0
                        : (wr_test ? (cmd_q[3:0] != `TEST_NORMAL) : test_q);
            req_q      <= done_any | (req_q & ~cmd_stb_q);
            div_q      <= sys_en ? '0 : div_q + DW'(1);
            phase_q    <= frame_end ? '0 : (sys_en ? phase_q + 8'h01 : phase_q);
        end
    end

    always_comb
    begin
        done_any = 1'b0;
        hit      = 1'b0;
        cmp      = freq_q ? phase_q[7:1] : phase_q[6:0];
        out_d    = '0;
        for (int p = 0; p < PORTS; p++)
        begin
            st_d[p] = st_q[p];
            hit     = (sel_q == 2'(p));
            if (hit && wr_lo && sweep_en_q)
            begin
                st_d[p].count = {upper_q, cmd_q[3:0]};
            end
            if (hit && wr_lo && !sweep_en_q)
            begin
                st_d[p].data = {upper_q, cmd_q[3:0]};
                st_d[p].load = 1'b1;
            end
            if (hit && wr_mode)
            begin
                st_d[p].led = cmd_q[1];
            end
            if (hit && wr_slope)
            begin
                st_d[p].slope  = cmd_q[3:2];
                st_d[p].step_t = cmd_q[1:0];
            end
            if (frame_end && st_q[p].load)
            begin
                st_d[p].level = st_q[p].data;
                st_d[p].load  = 1'b0;
            end
            if (frame_end && st_q[p].run && !st_q[p].load)
            begin
                if (st_q[p].fcnt + 6'h01 >= step_frames(st_q[p].step_t, st_q[p].led))
                begin
                    st_d[p].fcnt  = '0;
                    st_d[p].level = next_level(st_q[p].level, st_q[p].slope, st_q[p].led);
                    st_d[p].steps = st_q[p].steps - 8'h01;
                    if (st_q[p].steps <= 8'h01)
                    begin
                        st_d[p].run = 1'b0;
                        done_any    = done_any | ~abort;
                    end
                end
                else
                begin
                    st_d[p].fcnt = st_q[p].fcnt + 6'h01;
                end
            end
            if (prog_on && cmd_q[p])
            begin
                st_d[p].run   = 1'b1;
                st_d[p].load  = 1'b1;
                st_d[p].data  = st_q[p].load ? st_q[p].data : st_q[p].level;
                st_d[p].steps = st_q[p].count;
                st_d[p].fcnt  = '0;
            end
            if (abort || !sweep_en_q)
            begin
                st_d[p].run = 1'b0;
            end
            if (sclr)
            begin
                st_d[p] = '0;
            end
            out_d[p] = ({1'b0, cmp} < duty_of(st_q[p].level, st_q[p].led)) & ~test_q
                     & ~(keyscan_q && (p == `SCAN_PORT_IDX));
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int p = 0; p < PORTS; p++)
            begin
                st_q[p] <= '0;
            end
            pwm_out_ports <= '0;
        end
        else
        begin
            for (int p = 0; p < PORTS; p++)
            begin
                st_q[p] <= st_d[p];
            end
            pwm_out_ports <= out_d;
        end
    end

endmodule

`default_nettype wire

// [verilog/pwm_sweep_host.sv]
// host end: sends instruction bytes serially, watches request line
// assumes: device samples link with two-flop synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sweep_defines.svh"

module pwm_sweep_host
    import pwm_sweep_pkg::*;
#(
    parameter int HALF_BIT = 8
)
(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_byte,
    output logic             cmd_ready,
    output logic             sweep_request,
    pwm_link_if.host         link
);

    localparam int DW = $clog2(HALF_BIT) + 1;

    if (HALF_BIT < 4)
    begin : g_chk_half
        $error("HALF_BIT must be at least 4");
    end

    host_state_t    state_q;
    logic [DW-1:0]  div_q;
    logic [2:0]     bit_q;
    logic [7:0]     sh_q;
    logic           ce_q;
    logic           scl_q;
    logic           din_q;
    logic [1:0]     req_s_q;

    wire half_done = (div_q == DW'(HALF_BIT - 1));
    // bytes leave in accepted order, so level nibble order is kept
    wire send      = cmd_valid & (cmd_byte[7:4] != `OP_TEST);

    assign cmd_ready     = (state_q == H_IDLE);
    assign sweep_request = req_s_q[1];
    assign link.ce       = ce_q;
    assign link.scl      = scl_q;
    assign link.ser_din  = din_q;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            req_s_q <= '0;
        end
        else
        begin
            req_s_q <= {req_s_q[0], ~link.serial_data_line};
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_q <= H_IDLE;
            div_q   <= '0;
            bit_q   <= '0;
            sh_q    <= '0;
            ce_q    <= 1'b0;
            scl_q   <= 1'b0;
            din_q   <= 1'b0;
        end
        else
        begin
            div_q <= (state_q == H_IDLE || half_done) ? '0 : div_q + DW'(1);
            case (state_q)
                H_IDLE:
                begin
                    if (send)
                    begin
                        sh_q    <= cmd_byte;
                        din_q   <= cmd_byte[7];
                        ce_q    <= 1'b1;
                        bit_q   <= '0;
                        state_q <= H_LOW;
                    end
                end
                H_LOW:
                begin
                    if (half_done)
                    begin
                        scl_q   <= 1'b1;
                        state_q <= H_HIGH;
                    end
                end
                H_HIGH:
                begin
                    if (half_done)
                    begin
                        scl_q <= 1'b0;
                        if (bit_q == `CMD_BITS)
                        begin
                            state_q <= H_HOLD;
                        end
                        else
                        begin
                            bit_q   <= bit_q + 3'h1;
                            sh_q    <= {sh_q[6:0], 1'b0};
                            din_q   <= sh_q[6];
                            state_q <= H_LOW;
                        end
                    end
                end
                H_HOLD:
                begin
                    if (half_done)
                    begin
                        ce_q    <= 1'b0;
                        state_q <= H_OFF;
                    end
                end
                H_OFF:
                begin
                    if (half_done)
                    begin
                        state_q <= H_IDLE;
                    end
                end
                default:
                begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// [testbench/pwm_link_checker.sv]
// assertions on the serial link between host end and device end
// assumes: instantiated in the bench beside the link interface
`timescale 1ns/1ps
`default_nettype none

module pwm_link_checker
#(
    parameter int HALF_BIT = 8
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic scl,
    input wire logic ser_din,
    input wire logic req_o,
    input wire logic req_oe_n,
    input wire logic serial_data_line
);
    logic [4:0] idle_q;
    logic [7:0] high_q;
    logic [3:0] rise_q;
    logic       scl_q;

    // idle_q: cycles since ce was last high, saturating
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            idle_q <= 5'h1F;
            high_q <= 8'h00;
            rise_q <= 4'h0;
            scl_q  <= 1'b0;
        end
        else
        begin
            idle_q <= ce ? 5'h00 : ((idle_q == 5'h1F) ? idle_q : idle_q + 5'h01);
            high_q <= scl ? high_q + 8'h01 : 8'h00;
            rise_q <= !ce ? 4'h0 : rise_q + {3'h0, scl & !scl_q};
            scl_q  <= scl;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    chk_req_pulls_low: assert property (!req_oe_n |-> !req_o && !serial_data_line)
        else $error("request not driven low");
    chk_req_held_write: assert property ($rose(req_oe_n) |-> idle_q < 5'h10)
        else $error("request released without a write");
    chk_scl_in_frame: assert property (scl |-> ce)
        else $error("serial clock outside frame");
    chk_data_stable: assert property (scl && $past(scl) |-> $stable(ser_din))
        else $error("data moved while clock high");
    chk_scl_high_len: assert property ($fell(scl) |-> high_q == 8'(HALF_BIT))
        else $error("clock high phase wrong length");
    chk_eight_bits: assert property ($fell(ce) |-> rise_q == 4'h8)
        else $error("frame not eight bits");
    chk_frame_gap: assert property ($fell(ce) |=> !ce [*3])
        else $error("frames too close");
    chk_frame_start: assert property ($rose(ce) |-> !scl ##1 !scl)
        else $error("clock not low at frame start");
endmodule

`default_nettype wire

// [testbench/pwm_port_sweep_generator_tb.sv]
// bench: host end drives the device end over the link, ports are measured
// assumes: package, header, link interface and both ends compiled first
`timescale 1ns/1ps
`default_nettype none

module pwm_port_sweep_generator_tb;
    localparam int HALF  = 4;
    localparam int FRAME = 128;
    typedef logic [7:0] byte_list_t [$];

    logic       clk_sys   = 1'b0;
    logic       resetn    = 1'b0;
    logic       cmd_valid = 1'b0;
    logic [7:0] cmd_byte  = 8'h00;
    logic       cmd_ready;
    logic       sweep_request;
    logic [3:0] pwm_out_ports;
    logic       test_active;
    int         errors = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    int         led_duty [16] = '{0, 1, 2, 3, 5, 8, 13, 19, 27, 36, 46, 59, 73, 90, 108, 128};

    always #2.5 clk_sys = ~clk_sys;

    pwm_link_if i_pwm_link_if ();

    pwm_sweep_host #(.HALF_BIT(HALF)) i_pwm_sweep_host
    (
        .clk_sys       (clk_sys),
        .resetn        (resetn),
        .cmd_valid     (cmd_valid),
        .cmd_byte      (cmd_byte),
        .cmd_ready     (cmd_ready),
        .sweep_request (sweep_request),
        .link          (i_pwm_link_if)
    );

    pwm_sweep_device #(.PORTS(4), .SYS_DIV(1)) i_pwm_sweep_device
    (
        .clk_sys       (clk_sys),
        .resetn        (resetn),
        .link          (i_pwm_link_if),
        .pwm_out_ports (pwm_out_ports),
        .test_active   (test_active)
    );

    pwm_link_checker #(.HALF_BIT(HALF)) i_pwm_link_checker
    (
        .clk_sys          (clk_sys),
        .resetn           (resetn),
        .ce               (i_pwm_link_if.ce),
        .scl              (i_pwm_link_if.scl),
        .ser_din          (i_pwm_link_if.ser_din),
        .req_o            (i_pwm_link_if.req_o),
        .req_oe_n         (i_pwm_link_if.req_oe_n),
        .serial_data_line (i_pwm_link_if.serial_data_line)
    );

    task automatic wrap_up();
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check_num(input int got, input int exp, input string what);
        samples_checked++;
        if (got != exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %0d wanted %0d", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s is %b", $time, what, got);
        end
    endtask

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 95000)
        begin
            check_num(0, 1, "timeout");
            wrap_up();
        end
    end

    task automatic do_reset();
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
    endtask

    // ready is looked at off the edge, then the task returns on a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge clk_sys);
        while (cmd_ready !== 1'b1 && n < 400)
        begin
            @(negedge clk_sys);
            n++;
        end
        @(posedge clk_sys);
    endtask

    task automatic send_all(input byte_list_t bs);
        foreach (bs[i])
        begin
            wait_ready();
            cmd_valid <= 1'b1;
            cmd_byte  <= bs[i];
            @(posedge clk_sys);
            cmd_valid <= 1'b0;
            // host has left idle by now unless the byte is a test opcode, so this waits for the whole byte
            wait_ready();
            // device commits a few cycles after the last bit
            repeat (8) @(posedge clk_sys);
        end
    endtask

    // waits two periods for the new level to land, then counts high cycles
    task automatic check_duty(input int port, input int len, input int exp, input string what);
        int hi;
        hi = 0;
        repeat (2 * len) @(posedge clk_sys);
        repeat (len)
        begin
            @(negedge clk_sys);
            if (pwm_out_ports[port] === 1'b1)
                hi++;
        end
        check_num(hi, exp, what);
    endtask

    task automatic t_reset_state();
        check_bit(|pwm_out_ports, 1'b0, "ports idle");
        check_bit(i_pwm_link_if.serial_data_line, 1'b1, "line idle");
        check_bit(sweep_request, 1'b0, "request idle");
        check_bit(test_active, 1'b0, "test idle");
    endtask

    task automatic t_general();
        logic [7:0] lv [4] = '{8'h00, 8'h41, 8'h7F, 8'hC5};
        int         ex [4] = '{0, 65, 127, 128};
        send_all('{8'h64});
        for (int p = 0; p < 4; p++)
            send_all('{8'h60 | 8'(p), 8'h80 | {4'h0, lv[p][7:4]}, 8'h70 | {4'h0, lv[p][3:0]}});
        for (int p = 0; p < 4; p++)
            check_duty(p, FRAME, ex[p], "general level");
        send_all('{8'h60, 8'h83});
        check_duty(0, FRAME, 0, "upper nibble alone");
        send_all('{8'h77});
        check_duty(0, FRAME, 55, "both nibbles");
    endtask

    task automatic t_led();
        send_all('{8'h60, 8'h66});
        for (int c = 0; c < 16; c++)
        begin
            send_all('{8'h8F, 8'h70 | 8'(c)});
            check_duty(0, FRAME, led_duty[c], "led code");
        end
        check_duty(1, FRAME, 65, "other port general");
        send_all('{8'h64});
    endtask

    task automatic t_freq();
        send_all('{8'h51, 8'h60, 8'h80, 8'h75});
        check_duty(0, 2 * FRAME, 10, "long period");
        send_all('{8'h50});
        check_duty(0, FRAME, 5, "short period");
        send_all('{8'h52});
        check_duty(3, FRAME, 0, "fourth port given to key scan");
    endtask

    task automatic run_sweep(input logic led, input logic [7:0] start, input logic [7:0] steps,
                             input logic [7:0] slope, input int fin, input int fps);
        int n;
        int nom;
        n = 0;
        nom = steps * fps * FRAME;
        send_all('{8'h64 | {6'h00, led, 1'b0}, 8'h60, 8'h80 | {4'h0, start[7:4]},
                   8'h70 | {4'h0, start[3:0]}, 8'h65 | {6'h00, led, 1'b0},
                   8'h80 | {4'h0, steps[7:4]}, 8'h70 | {4'h0, steps[3:0]}, slope, 8'h9F});
        send_all('{8'hC1});
        while (sweep_request !== 1'b1 && n < nom + 4 * FRAME)
        begin
            @(posedge clk_sys);
            n++;
        end
        check_bit(n >= nom - 2 * FRAME && n <= nom + 2 * FRAME, 1'b1, "sweep length");
        check_bit(sweep_request, 1'b1, "host sees request");
        check_duty(0, FRAME, fin, "final level");
        check_bit(i_pwm_link_if.serial_data_line, 1'b0, "request held");
        send_all('{8'h60});
        check_bit(sweep_request, 1'b0, "request after write");
    endtask

    task automatic t_sweeps();
        run_sweep(1'b0, 8'h08, 8'h0C, 8'h94, 20, 4);
        run_sweep(1'b1, 8'h08, 8'h0C, 8'h94, 5, 8);
        run_sweep(1'b1, 8'h02, 8'h05, 8'h99, 90, 16);
        run_sweep(1'b0, 8'h1E, 8'h02, 8'h93, 30, 16);
        run_sweep(1'b0, 8'h7F, 8'h02, 8'h94, 0, 4);
    endtask

    task automatic t_abort();
        int n;
        n = 0;
        send_all('{8'h64, 8'h60, 8'h80, 8'h70, 8'h65, 8'h80, 8'h7A, 8'h94, 8'hC1});
        repeat (8 * FRAME) @(posedge clk_sys);
        send_all('{8'h64, 8'hC1});
        repeat (60 * FRAME)
        begin
            @(posedge clk_sys);
            if (sweep_request !== 1'b0)
                n++;
        end
        check_num(n, 0, "request after abort");
    endtask

    task automatic t_reset_paths();
        send_all('{8'h60, 8'h80, 8'h73, 8'hF3});
        check_bit(test_active, 1'b0, "test byte held back");
        check_duty(0, FRAME, 3, "level before reset instruction");
        send_all('{8'hE2});
        check_duty(0, FRAME, 0, "reset instruction");
        send_all('{8'h80, 8'h73});
        do_reset();
        @(posedge clk_sys);
        t_reset_state();
    endtask

    initial
    begin
        do_reset();
        @(posedge clk_sys);
        t_reset_state();
        t_general();
        t_led();
        t_freq();
        t_sweeps();
        t_abort();
        t_reset_paths();
        wrap_up();
    end
endmodule

`default_nettype wire
